//--- src/wdsup_top.sv
`timescale 1ns/1ps
// Contract
// RL1: Capture control strap after reset; low selects pin control, else serial control.
// RL2: Pin control takes window length from the window strap level.
// RL3: Pin control uses trigger pin transitions as refresh, expected in open window.
// RL4: Watchdog error drives the watchdog reset output low.
// RL5: Serial control refreshes on writing ff to trigger register 15h.
// RL6: Host refreshes inside the window of every period.
// RL7: Serial control may turn system reset output into the watchdog event output.
// RL8: Entering standby, normal or fast starts an extended initial window.
// RL9: Pin control holds system reset high while supply good and not restarting.
// RL10: Serial control configures reset output behaviour through register writes.
// RL11: Strap levels give roughly 40 ms, 600 ms and 6 s windows.
// RL12: Closed and open halves each take half of the window.
// RL13: Either trigger edge refreshes after a glitch filter.
// RL14: Trigger in closed half or none by end of open half is an error.
module wdsup_top import wdsup_pkg::*; #(
  parameter logic [WIN_W-1:0] WIN_GND_CYC = WIN_W'(WIN_GND_CYC_DEF),
  parameter logic [WIN_W-1:0] WIN_VCC_CYC = WIN_W'(WIN_VCC_CYC_DEF),
  parameter logic [WIN_W-1:0] WIN_OPEN_CYC = WIN_W'(WIN_OPEN_CYC_DEF),
  parameter logic [CNT_W-1:0] WDR_CYC = CNT_W'(WDR_CYC_DEF)
) (
  // Clock and reset
  input logic clk,
  input logic reset_n,
  // Straps, supply and device mode
  input logic chip_select_bar,
  input logic [1:0] window_select_strap,
  input logic vcc_above_uv,
  input wdsup_mode_e op_mode,
  // Trigger pin and serial clock
  input logic refresh_trigger_input,
  input logic spi_clk,
  // Outputs
  output logic watchdog_reset_out_n,
  output logic system_reset_out_n,
  output logic spi_control
);
  // ****************************************************************
  // Reset release and input synchronisers
  // ****************************************************************
  logic [1:0] rst_pipe;
  logic rst_n;
  logic s_csb, s_trig, s_sclk, s_uv;
  logic [1:0] s_wsel;

  // Reset asserts at once and releases after two edges
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  wdsup_sync #(.W(6)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({chip_select_bar, window_select_strap, refresh_trigger_input, spi_clk, vcc_above_uv}),
    .sync_out({s_csb, s_wsel, s_trig, s_sclk, s_uv})
  );

  // ****************************************************************
  // Strap capture, trigger filter and serial receiver
  // ****************************************************************
  logic [1:0] strap_cnt, next_strap_cnt;
  logic strap_done, next_strap_done, spi_ctl, next_spi_ctl;
  logic filt_lvl, next_filt_lvl, pin_refresh;
  logic [FILT_W-1:0] filt_cnt, next_filt_cnt;
  logic sclk_q, next_sclk_q, frame_vld, next_frame_vld;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic [15:0] shreg, next_shreg;
  logic [2:0] cfg, next_cfg;
  logic spi_refresh, cfg_wr;
  wdsup_frame_s frame;

  assign frame = wdsup_frame_s'(shreg);
  assign spi_refresh = frame_vld && spi_ctl && frame.wr && frame.addr == TRIG_ADDR
                       && frame.data == TRIG_KEY; // [RL5]
  assign cfg_wr = frame_vld && spi_ctl && frame.wr && frame.addr == CFG_ADDR;
  assign pin_refresh = strap_done && !spi_ctl && s_trig != filt_lvl && filt_cnt == FILT_CYC - 8'h1; // [RL3] [RL13]

  // Next values of strap, filter and serial state
  always_comb begin
    next_strap_cnt = strap_cnt;
    next_strap_done = strap_done;
    next_spi_ctl = spi_ctl;
    next_filt_lvl = filt_lvl;
    next_filt_cnt = filt_cnt;
    next_sclk_q = s_sclk;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_frame_vld = 1'b0;
    next_cfg = cfg;
    if (!strap_done) begin
      if (strap_cnt == STRAP_WAIT) begin
        next_strap_done = 1'b1;
        next_spi_ctl = s_csb; // [RL1]
      end else begin
        next_strap_cnt = strap_cnt + 2'h1;
      end
    end
    if (s_trig == filt_lvl) begin
      next_filt_cnt = '0;
    end else if (filt_cnt == FILT_CYC - 8'h1) begin
      next_filt_lvl = s_trig; // [RL13]
      next_filt_cnt = '0;
    end else begin
      next_filt_cnt = filt_cnt + 8'h1;
    end
    if (s_csb || !spi_ctl) begin
      next_bit_cnt = 5'h0;
    end else if (s_sclk && !sclk_q && bit_cnt < FRAME_BITS) begin
      next_shreg = {shreg[14:0], s_trig};
      next_bit_cnt = bit_cnt + 5'h1;
      next_frame_vld = bit_cnt == FRAME_BITS - 5'h1;
    end
    if (cfg_wr) begin
      next_cfg = frame.data[2:0]; // [RL10]
    end
  end

  // Register strap, filter and serial state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt <= 2'h0;
      strap_done <= 1'b0;
      spi_ctl <= 1'b0;
      filt_lvl <= 1'b0;
      filt_cnt <= '0;
      sclk_q <= 1'b0;
      bit_cnt <= 5'h0;
      shreg <= 16'h0;
      frame_vld <= 1'b0;
      cfg <= CFG_RESET;
    end else begin
      strap_cnt <= next_strap_cnt;
      strap_done <= next_strap_done;
      spi_ctl <= next_spi_ctl;
      filt_lvl <= next_filt_lvl;
      filt_cnt <= next_filt_cnt;
      sclk_q <= next_sclk_q;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      frame_vld <= next_frame_vld;
      cfg <= next_cfg;
    end
  end

  // ****************************************************************
  // Window timer
  // ****************************************************************
  wdsup_state_e state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt, init_end, half_end;
  logic [WIN_W-1:0] win;
  logic [1:0] wsel_code;
  logic active, refresh, rst_as_wd, next_wdr_n, next_sys_n;

  assign rst_as_wd = cfg[CFG_RSTWD_BIT];
  assign wsel_code = spi_ctl ? cfg[CFG_WSEL_LSB +: 2] : s_wsel; // [RL2]
  assign active = strap_done && (op_mode == MODE_STANDBY || op_mode == MODE_NORMAL || op_mode == MODE_FAST);
  assign refresh = spi_ctl ? spi_refresh : pin_refresh;
  assign init_end = {win, 1'b0} - 29'h1; // [RL8]
  assign half_end = {1'b0, win >> 1} - 29'h1; // [RL12]

  // Window length from the selected range
  always_comb begin
    case (wsel_code)
      WSEL_GND: win = WIN_GND_CYC; // [RL11]
      WSEL_VCC: win = WIN_VCC_CYC; // [RL11]
      default: win = WIN_OPEN_CYC; // [RL11]
    endcase
  end

  // Next window state and output levels
  always_comb begin
    next_state = state;
    next_cnt = cnt + 29'h1;
    case (state)
      WD_OFF: begin
        next_cnt = '0;
        next_state = WD_INIT; // [RL8]
      end
      WD_INIT: begin
        if (refresh) begin
          next_state = WD_CLOSED;
          next_cnt = '0;
        end else if (cnt == init_end) begin
          next_state = WD_FAULT;
          next_cnt = '0;
        end
      end
      WD_CLOSED: begin
        if (refresh) begin
          next_state = WD_FAULT; // [RL14]
          next_cnt = '0;
        end else if (cnt == half_end) begin
          next_state = WD_OPEN; // [RL12]
          next_cnt = '0;
        end
      end
      WD_OPEN: begin
        if (refresh) begin
          next_state = WD_CLOSED; // [RL3] [RL5]
          next_cnt = '0;
        end else if (cnt == half_end) begin
          next_state = WD_FAULT; // [RL14]
          next_cnt = '0;
        end
      end
      WD_FAULT: begin
        if (cnt == WDR_CYC - 29'h1) begin
          next_state = WD_INIT;
          next_cnt = '0;
        end
      end
      default: begin
        next_state = WD_OFF;
        next_cnt = '0;
      end
    endcase
    if (!active) begin
      next_state = WD_OFF;
      next_cnt = '0;
    end
    next_wdr_n = next_state != WD_FAULT; // [RL4]
    if (spi_ctl && rst_as_wd) begin
      next_sys_n = next_state != WD_FAULT; // [RL7]
    end else begin
      next_sys_n = strap_done && s_uv && op_mode != MODE_RESTART; // [RL9]
    end
  end

  // Register window state and outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= WD_OFF;
      cnt <= '0;
      watchdog_reset_out_n <= 1'b1;
      system_reset_out_n <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      watchdog_reset_out_n <= next_wdr_n;
      system_reset_out_n <= next_sys_n;
    end
  end
  assign spi_control = spi_ctl;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_strap_capture: assert property ($rose(strap_done) |-> spi_ctl == $past(s_csb)) // [RL1]
    else $error("control strap not captured");
  chk_win_strap: assert property (!spi_ctl && s_wsel == WSEL_VCC |-> win == WIN_VCC_CYC) // [RL2]
    else $error("window not taken from strap");
  chk_win_ranges: assert property (!spi_ctl && s_wsel == WSEL_GND |-> win == WIN_GND_CYC) // [RL11]
    else $error("ground range wrong");
  chk_pin_refresh: assert property (state == WD_OPEN && pin_refresh && active |=> state == WD_CLOSED && cnt == 0) // [RL3]
    else $error("pin refresh did not restart window");
  chk_fault_out: assert property (state == WD_FAULT |-> !watchdog_reset_out_n) // [RL4]
    else $error("watchdog reset not low on fault");
  chk_spi_trigger: assert property (spi_refresh && state == WD_OPEN && active |=> state == WD_CLOSED) // [RL5]
    else $error("trigger write did not restart window");
  chk_event_output: assert property (spi_ctl && rst_as_wd && state == WD_FAULT |-> !system_reset_out_n) // [RL7]
    else $error("system reset not acting as event output");
  chk_init_entry: assert property (state == WD_OFF && active |=> state == WD_INIT && cnt == 0) // [RL8]
    else $error("initial window not started");
  chk_sysrst_level: assert property (!spi_ctl && strap_done && s_uv && op_mode != MODE_RESTART
                                     |=> system_reset_out_n) // [RL9]
    else $error("system reset low with good supply");
  chk_cfg_write: assert property (cfg_wr |=> rst_as_wd == $past(frame.data[CFG_RSTWD_BIT])) // [RL10]
    else $error("configuration write lost");
  chk_open_half: assert property (state == WD_CLOSED && cnt == half_end && !refresh && active
                                  |=> state == WD_OPEN) // [RL12]
    else $error("open half not entered");
  chk_glitch_reject: assert property (pin_refresh |-> filt_cnt == FILT_CYC - 8'h1 && s_trig != filt_lvl) // [RL13]
    else $error("unfiltered trigger accepted");
  chk_closed_fault: assert property (state == WD_CLOSED && refresh && active |=> state == WD_FAULT) // [RL14]
    else $error("early trigger not flagged");

  cov_pin_refresh: cover property (state == WD_OPEN && pin_refresh);
  cov_spi_refresh: cover property (state == WD_OPEN && spi_refresh);
  cov_timeout: cover property (state == WD_OPEN ##1 state == WD_FAULT);
endmodule : wdsup_top

//--- shared/wdsup_pkg.sv
// ****************************************************************
// Window watchdog supervisor constants and types
// ****************************************************************
package wdsup_pkg;
  // Clock rate
  localparam longint unsigned CLK_KHZ = 40000;
  // Nominal window lengths per strap level, centre of each range
  localparam longint unsigned WIN_GND_US = 40000;
  localparam longint unsigned WIN_VCC_US = 600000;
  localparam longint unsigned WIN_OPEN_US = 6000000;
  // Width of the low pulse on the watchdog reset output
  localparam longint unsigned WDR_US = 2000;
  // Trigger glitch filter time
  localparam longint unsigned FILT_NS = 1000;
  localparam int WIN_W = 28;
  localparam int CNT_W = WIN_W + 1;
  localparam longint unsigned WIN_GND_CYC_DEF = WIN_GND_US * CLK_KHZ / 1000;
  localparam longint unsigned WIN_VCC_CYC_DEF = WIN_VCC_US * CLK_KHZ / 1000;
  localparam longint unsigned WIN_OPEN_CYC_DEF = WIN_OPEN_US * CLK_KHZ / 1000;
  localparam longint unsigned WDR_CYC_DEF = WDR_US * CLK_KHZ / 1000;
  localparam int FILT_W = 8;
  localparam logic [FILT_W-1:0] FILT_CYC = FILT_W'((FILT_NS * CLK_KHZ + 999999) / 1000000);
  // Strap settling after reset release
  localparam logic [1:0] STRAP_WAIT = 2'h2;
  // Window select codes of the sensed strap level
  localparam logic [1:0] WSEL_GND = 2'h0;
  localparam logic [1:0] WSEL_VCC = 2'h1;
  localparam logic [1:0] WSEL_OPEN = 2'h2;
  // Serial frame and register map
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [6:0] TRIG_ADDR = 7'h15;
  localparam logic [7:0] TRIG_KEY = 8'hff;
  localparam logic [6:0] CFG_ADDR = 7'h1a;
  localparam int CFG_RSTWD_BIT = 0;
  localparam int CFG_WSEL_LSB = 1;
  localparam logic [2:0] CFG_RESET = 3'h0;

  // Operating mode of the surrounding device
  typedef enum logic [2:0] {
    MODE_SLEEP, MODE_RESTART, MODE_STANDBY, MODE_NORMAL, MODE_FAST
  } wdsup_mode_e;

  // Watchdog states
  typedef enum logic [2:0] {
    WD_OFF, WD_INIT, WD_CLOSED, WD_OPEN, WD_FAULT
  } wdsup_state_e;

  // One serial frame, first bit shifted in is addr[6]
  typedef struct packed {
    logic [6:0] addr;
    logic wr;
    logic [7:0] data;
  } wdsup_frame_s;
endpackage : wdsup_pkg

//--- src/wdsup_sync.sv
`timescale 1ns/1ps
// ****************************************************************
// Two flip-flop synchroniser
// ****************************************************************
module wdsup_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input logic clk,
  input logic rst_n,
  // Asynchronous inputs and synchronised copies
  input logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : wdsup_sync

//--- verif/wdsup_host.sv
`timescale 1ns/1ps
// ****************************************************************
// Supervised host model: trigger pin and serial writes
// ****************************************************************
module wdsup_host import wdsup_pkg::*; (
  // Clock
  input wire logic clk,
  // Pins toward the supervisor
  output logic chip_select_bar,
  output logic spi_clk,
  output logic refresh_trigger_input
);
  // Idle levels: serial clock stands low outside frames
  initial begin
    chip_select_bar = 1'b0;
    spi_clk = 1'b0;
    refresh_trigger_input = 1'b0;
  end

  // Wait n clock edges
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask : hold

  // Hold the select pin at its strap level
  task automatic set_strap(input logic lvl);
    @(posedge clk);
    chip_select_bar <= lvl;
  endtask : set_strap

  // One transition on the trigger pin
  task automatic toggle();
    @(posedge clk);
    refresh_trigger_input <= ~refresh_trigger_input;
  endtask : toggle

  // Short pulse, returns the pin to its old level
  task automatic pulse(input int n);
    toggle();
    hold(n);
    toggle();
  endtask : pulse

  // One write frame, first bit addr[6], clock high and low 3 cycles each
  task automatic write_frame(input logic [6:0] addr, input logic [7:0] data);
    wdsup_frame_s f;
    f = '{addr: addr, wr: 1'b1, data: data};
    @(posedge clk);
    chip_select_bar <= 1'b0;
    hold(3);
    for (int i = 15; i >= 0; i--) begin
      refresh_trigger_input <= f[i];
      spi_clk <= 1'b0;
      hold(3);
      spi_clk <= 1'b1;
      hold(3);
    end
    spi_clk <= 1'b0;
    hold(3);
    chip_select_bar <= 1'b1;
    refresh_trigger_input <= ~f[0]; // Released line shows no stale bit
    hold(3);
  endtask : write_frame
endmodule : wdsup_host

//--- verif/tb_window_watchdog_supervisor.sv
`timescale 1ns/1ps
// ****************************************************************
// Testbench for the window watchdog supervisor
// ****************************************************************
module tb_window_watchdog_supervisor import wdsup_pkg::*;;
  localparam int W_TAB [3] = '{200, 400, 800};
  localparam int WDR = 10;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] window_select_strap = 2'h0;
  logic vcc_above_uv = 1'b1;
  wdsup_mode_e op_mode = MODE_NORMAL;
  logic chip_select_bar;
  logic spi_clk;
  logic refresh_trigger_input;
  logic watchdog_reset_out_n;
  logic system_reset_out_n;
  logic spi_control;
  int miscompares = 0;
  int cmp_count = 0;
  int wd_low = 0;
  int sys_low = 0;
  int base;
  int base2;
  int w;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  localparam int LIMIT = 3000;

  // ****************************************************************
  // Device and host model
  // ****************************************************************
  wdsup_top #(
    .WIN_GND_CYC(WIN_W'(W_TAB[0])),
    .WIN_VCC_CYC(WIN_W'(W_TAB[1])),
    .WIN_OPEN_CYC(WIN_W'(W_TAB[2])),
    .WDR_CYC(CNT_W'(WDR))
  ) i_dut (
    .clk(clk),
    .reset_n(reset_n),
    .chip_select_bar(chip_select_bar),
    .window_select_strap(window_select_strap),
    .vcc_above_uv(vcc_above_uv),
    .op_mode(op_mode),
    .refresh_trigger_input(refresh_trigger_input),
    .spi_clk(spi_clk),
    .watchdog_reset_out_n(watchdog_reset_out_n),
    .system_reset_out_n(system_reset_out_n),
    .spi_control(spi_control)
  );

  wdsup_host i_host (
    .clk(clk),
    .chip_select_bar(chip_select_bar),
    .spi_clk(spi_clk),
    .refresh_trigger_input(refresh_trigger_input)
  );

  // Count low cycles of both reset outputs at settled points
  always @(negedge clk) begin
    if (reset_n && watchdog_reset_out_n === 1'b0) begin
      wd_low++;
    end
    if (reset_n && system_reset_out_n === 1'b0) begin
      sys_low++;
    end
  end

  // ****************************************************************
  // Compare, wait and report tasks
  // ****************************************************************
  task automatic cmp_bit(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask : cmp_bit

  task automatic cmp_int(input string name, input int exp, input int got);
    cmp_count++;
    if (got != exp) begin
      miscompares++;
      $display("[ERR] %s expected %0d seen %0d", name, exp, got);
    end
  endtask : cmp_int

  // Pick one of the two reset outputs
  function automatic logic out_of(input bit sys);
    return sys ? system_reset_out_n : watchdog_reset_out_n;
  endfunction : out_of

  // Wait at falling edges until the output shows lvl; a timeout ends the run
  task automatic wait_lvl(input bit sys, input logic lvl, output int n);
    n = 0;
    @(negedge clk);
    while (out_of(sys) !== lvl && n < LIMIT) begin
      @(negedge clk);
      n++;
    end
    if (n >= LIMIT) begin
      miscompares++;
      $display("[ERR] %s expected %b seen timeout", sys ? "system_reset_out_n" : "watchdog_reset_out_n", lvl);
      final_report();
    end
  endtask : wait_lvl

  // Length in cycles of the next run of lvl on the output
  task automatic run_len(input bit sys, input logic lvl, output int n);
    wait_lvl(sys, lvl, n);
    n = 0;
    while (out_of(sys) === lvl && n < LIMIT) begin
      @(negedge clk);
      n++;
    end
  endtask : run_len

  // Reset with the control strap held, then let the strap settle
  task automatic do_reset(input logic strap);
    i_host.set_strap(strap);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    i_host.hold(12);
    @(negedge clk);
  endtask : do_reset

  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    // Pin control, ground window, refreshes in the open half
    do_reset(1'b0);
    cmp_bit("spi_control", 1'b0, spi_control);
    cmp_bit("system_reset_out_n", 1'b1, system_reset_out_n);
    base = wd_low;
    repeat (4) begin
      i_host.toggle();
      i_host.hold(150);
    end
    cmp_int("wd_low good refresh", base, wd_low);
    $display("Test pin refresh done");
    // Early trigger in the closed half
    i_host.toggle();
    i_host.hold(60);
    i_host.toggle();
    run_len(1'b0, 1'b0, w);
    cmp_int("fault pulse", WDR, w);
    $display("Test early trigger done");
    // Glitch ignored, then initial window runs out
    base = wd_low;
    i_host.pulse(20);
    i_host.hold(300);
    cmp_int("wd_low after glitch", base, wd_low);
    wait_lvl(1'b0, 1'b0, w);
    run_len(1'b0, 1'b1, w);
    cmp_int("init window gnd", 2 * W_TAB[0], w);
    for (int i = 1; i < 3; i++) begin
      @(posedge clk);
      window_select_strap <= 2'(i);
      run_len(1'b0, 1'b1, w);
      cmp_int("init window strap", 2 * W_TAB[i], w);
    end
    $display("Test window ranges done");
    // System reset follows supply and restart mode
    @(posedge clk);
    vcc_above_uv <= 1'b0;
    i_host.hold(5);
    @(negedge clk);
    cmp_bit("system_reset_out_n", 1'b0, system_reset_out_n);
    @(posedge clk);
    vcc_above_uv <= 1'b1;
    op_mode <= MODE_RESTART;
    i_host.hold(5);
    @(negedge clk);
    cmp_bit("system_reset_out_n", 1'b0, system_reset_out_n);
    cmp_bit("watchdog_reset_out_n", 1'b1, watchdog_reset_out_n);
    @(posedge clk);
    op_mode <= MODE_NORMAL;
    i_host.hold(5);
    @(negedge clk);
    cmp_bit("system_reset_out_n", 1'b1, system_reset_out_n);
    $display("Test system reset done");
    // Serial control after a second reset
    do_reset(1'b1);
    cmp_bit("spi_control", 1'b1, spi_control);
    base = wd_low;
    base2 = sys_low;
    i_host.write_frame(CFG_ADDR, 8'h01);
    i_host.write_frame(TRIG_ADDR, TRIG_KEY);
    i_host.hold(30);
    i_host.write_frame(TRIG_ADDR, TRIG_KEY);
    i_host.hold(30);
    i_host.write_frame(TRIG_ADDR, 8'h55);
    run_len(1'b1, 1'b0, w);
    cmp_int("event pulse", WDR, w);
    cmp_int("sys_low serial", WDR, sys_low - base2);
    cmp_int("wd_low serial", WDR, wd_low - base);
    $display("Test serial control done");
    final_report();
  end
endmodule : tb_window_watchdog_supervisor
